// [rtl/sfcd_decoder.sv]
// serial flash command decoder with its write-data fifo
`timescale 1ns/100ps
`include "sfcd_cfg.svh"

module sfcd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SFCD_FIFO_DEPTH
) (
    input  wire logic             clk_in,       // clock
    input  wire logic             rst_in,       // async reset, high
    input  wire logic             in_valid_in,  // write strobe
    output logic                  in_ready_out, // room left
    input  wire logic [WIDTH-1:0] in_data_in,   // write data
    output logic                  out_valid_out,// data present
    input  wire logic             out_ready_in, // drain strobe
    output logic [WIDTH-1:0]      out_data_out  // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             wr_en;
    logic             rd_en;

    assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign wr_en = in_valid_in & in_ready_out;
    assign rd_en = out_ready_in & out_valid_out;

    always_ff @(posedge clk_in) begin
        if (wr_en) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (wr_en) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (rd_en) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
        end
    end
endmodule

module sfcd_decoder #(
    parameter int FIFO_DEPTH = `SFCD_FIFO_DEPTH
) (
    input  wire logic        mclk_in,        // system clock
    input  wire logic        sys_rst_in,     // async reset, high
    input  wire logic        cs_n_in,        // chip select pin, low
    input  wire logic        sck_in,         // serial clock pin
    input  wire logic        si_in,          // serial data in pin
    output logic             so_out,         // serial data out
    output logic             so_oe_out,      // so drive enable
    output logic             sio_out,        // second line in dual read
    output logic             sio_oe_out,     // sio drive enable
    output logic             cmd_start_out,  // header complete pulse
    output logic [7:0]       cmd_opcode_out, // decoded opcode
    output logic [22:0]      cmd_addr_out,   // array address
    output logic             cmd_end_out,    // command closed pulse
    output logic             overrun_out,    // data lost, fifo full
    input  wire logic [7:0]  tx_data_in,     // next byte to send
    output logic             tx_req_out,     // tx byte taken pulse
    output logic             wr_valid_out,   // write data present
    input  wire logic        wr_ready_in,    // write data taken
    output logic [7:0]       wr_data_out     // write data byte
);
    sfcd_pkg::sfcd_state_e state_q;
    sfcd_pkg::sfcd_info_s  info_q;
    sfcd_pkg::sfcd_info_s  look;
    logic       cs_m_q, cs_s_q;
    logic       sck_m_q, sck_s_q, sck_p_q;
    logic       si_m_q, si_s_q;
    logic       sck_rise, sck_fall, cs_act;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] byte_w;
    logic [1:0] cnt_q;
    logic [23:0] addr_q;
    logic [2:0] din_n_q;
    logic       started_q;
    logic       push_q;
    logic [7:0] push_data_q;
    logic       fifo_ready;
    logic [7:0] txsh_q;
    logic [2:0] tbit_q;
    logic [2:0] tbyte_q;
    logic       tx_last;

    function automatic sfcd_pkg::sfcd_info_s lookup(input logic [7:0] op);
        sfcd_pkg::sfcd_info_s r;
        r = '{valid: 1'b1, naddr: 2'h0, ndummy: 2'h0,
              dir: sfcd_pkg::SFCD_NONE, dual: 1'b0, maxb: 3'h0};
        case (op)
            `SFCD_OP_RD_HS, `SFCD_OP_OTP_RD: begin
                r.naddr  = `SFCD_ADDR_BYTES;
                r.ndummy = 2'h2;
                r.dir    = sfcd_pkg::SFCD_OUT;
            end
            `SFCD_OP_RD_FAST: begin
                r.naddr  = `SFCD_ADDR_BYTES;
                r.ndummy = 2'h1;
                r.dir    = sfcd_pkg::SFCD_OUT;
            end
            `SFCD_OP_RD_DUAL: begin
                r.naddr  = `SFCD_ADDR_BYTES;
                r.ndummy = 2'h1;
                r.dir    = sfcd_pkg::SFCD_OUT;
                r.dual   = 1'b1;
            end
            `SFCD_OP_RD_LF, `SFCD_OP_RD_PROT, `SFCD_OP_RD_LOCK: begin
                r.naddr = `SFCD_ADDR_BYTES;
                r.dir   = sfcd_pkg::SFCD_OUT;
            end
            `SFCD_OP_ER_4K, `SFCD_OP_ER_32K, `SFCD_OP_ER_64K,
            `SFCD_OP_PROT, `SFCD_OP_UNPROT: begin
                r.naddr = `SFCD_ADDR_BYTES;
            end
            `SFCD_OP_PROG, `SFCD_OP_PROG_DI, `SFCD_OP_OTP_PROG: begin
                r.naddr = `SFCD_ADDR_BYTES;
                r.dir   = sfcd_pkg::SFCD_IN;
            end
            `SFCD_OP_LOCK, `SFCD_OP_FREEZE: begin
                r.naddr = `SFCD_ADDR_BYTES;
                r.dir   = sfcd_pkg::SFCD_IN;
                r.maxb  = 3'h1;
            end
            `SFCD_OP_WR_STAT1, `SFCD_OP_WR_STAT2,
            `SFCD_OP_RESET: begin
                r.dir  = sfcd_pkg::SFCD_IN;
                r.maxb = 3'h1;
            end
            `SFCD_OP_RD_STAT: begin
                r.dir = sfcd_pkg::SFCD_OUT;
            end
            `SFCD_OP_RD_ID: begin
                r.dir  = sfcd_pkg::SFCD_OUT;
                r.maxb = `SFCD_ID_MAX;
            end
            `SFCD_OP_ER_CHIPA, `SFCD_OP_ER_CHIPB,
            `SFCD_OP_SUSPEND, `SFCD_OP_RESUME,
            `SFCD_OP_WR_EN, `SFCD_OP_WR_DIS,
            `SFCD_OP_PD_ENTER, `SFCD_OP_PD_EXIT: begin
                r.valid = 1'b1;
            end
            default: begin
                r.valid = 1'b0;
            end
        endcase
        return r;
    endfunction

    // pins cross two flops; edges are found on the settled copies
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_m_q  <= 1'b1;
            cs_s_q  <= 1'b1;
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_p_q <= 1'b0;
            si_m_q  <= 1'b0;
            si_s_q  <= 1'b0;
        end else begin
            cs_m_q  <= cs_n_in;
            cs_s_q  <= cs_m_q;
            sck_m_q <= sck_in;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
            si_m_q  <= si_in;
            si_s_q  <= si_m_q;
        end
    end

    assign sck_rise = sck_s_q & ~sck_p_q;
    assign sck_fall = ~sck_s_q & sck_p_q;
    assign cs_act   = ~cs_s_q;
    assign byte_w   = {sh_q[6:0], si_s_q};
    assign look     = lookup(byte_w);

    // command framing
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q     <= sfcd_pkg::SFCD_IDLE;
            info_q      <= '0;
            bit_q       <= 3'h0;
            sh_q        <= 8'h00;
            cnt_q       <= 2'h0;
            addr_q      <= 24'h000000;
            din_n_q     <= 3'h0;
            started_q   <= 1'b0;
            cmd_start_out  <= 1'b0;
            cmd_end_out    <= 1'b0;
            cmd_opcode_out <= 8'h00;
            overrun_out <= 1'b0;
            push_q      <= 1'b0;
            push_data_q <= 8'h00;
        end else begin
            cmd_start_out <= 1'b0;
            cmd_end_out   <= 1'b0;
            overrun_out   <= 1'b0;
            push_q        <= 1'b0;
            if (!cs_act) begin
                // no start was flagged if the header was short
                cmd_end_out <= started_q;
                started_q   <= 1'b0;
                state_q     <= sfcd_pkg::SFCD_IDLE;
                bit_q       <= 3'h0;
            end else if (state_q == sfcd_pkg::SFCD_IDLE) begin
                state_q <= sfcd_pkg::SFCD_OPC;
                bit_q   <= 3'h0;
                cnt_q   <= 2'h0;
                din_n_q <= 3'h0;
            end else if (state_q == sfcd_pkg::SFCD_HDR) begin
                cmd_start_out <= 1'b1;
                started_q     <= 1'b1;
                case (info_q.dir)
                    sfcd_pkg::SFCD_IN:  state_q <= sfcd_pkg::SFCD_DIN;
                    sfcd_pkg::SFCD_OUT: state_q <= sfcd_pkg::SFCD_DOUT;
                    // opcode-only or address-only: extra bits dropped
                    default: state_q <= sfcd_pkg::SFCD_IGN;
                endcase
            end else if (sck_rise && state_q != sfcd_pkg::SFCD_IGN &&
                         state_q != sfcd_pkg::SFCD_DOUT) begin
                sh_q  <= byte_w;
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    case (state_q)
                        sfcd_pkg::SFCD_OPC: begin
                            cmd_opcode_out <= byte_w;
                            info_q <= look;
                            if (!look.valid) begin
                                state_q <= sfcd_pkg::SFCD_IGN;
                            end else if (look.naddr != 2'h0) begin
                                state_q <= sfcd_pkg::SFCD_ADDR;
                            end else begin
                                state_q <= sfcd_pkg::SFCD_HDR;
                            end
                        end
                        sfcd_pkg::SFCD_ADDR: begin
                            addr_q <= {addr_q[15:0], byte_w};
                            cnt_q  <= cnt_q + 2'h1;
                            if (cnt_q == info_q.naddr - 2'h1) begin
                                cnt_q   <= 2'h0;
                                state_q <= (info_q.ndummy != 2'h0) ?
                                           sfcd_pkg::SFCD_DUMMY :
                                           sfcd_pkg::SFCD_HDR;
                            end
                        end
                        sfcd_pkg::SFCD_DUMMY: begin
                            cnt_q <= cnt_q + 2'h1;
                            if (cnt_q == info_q.ndummy - 2'h1) begin
                                state_q <= sfcd_pkg::SFCD_HDR;
                            end
                        end
                        sfcd_pkg::SFCD_DIN: begin
                            // the link cannot stall, so a full fifo
                            // ends intake for this command
                            if (fifo_ready) begin
                                push_q      <= 1'b1;
                                push_data_q <= byte_w;
                                din_n_q     <= din_n_q + 3'h1;
                                if (info_q.maxb != 3'h0 &&
                                    din_n_q + 3'h1 == info_q.maxb) begin
                                    state_q <= sfcd_pkg::SFCD_IGN;
                                end
                            end else begin
                                overrun_out <= 1'b1;
                                state_q     <= sfcd_pkg::SFCD_IGN;
                            end
                        end
                        default: begin
                            state_q <= sfcd_pkg::SFCD_IGN;
                        end
                    endcase
                end
            end
        end
    end

    assign cmd_addr_out = addr_q[22:0];

    assign tx_last = info_q.dual ? (tbit_q == 3'h3) : (tbit_q == 3'h7);

    // read data, driven on falling edges
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            txsh_q     <= 8'h00;
            tbit_q     <= 3'h0;
            tbyte_q    <= 3'h0;
            tx_req_out <= 1'b0;
            so_out     <= 1'b0;
            sio_out    <= 1'b0;
            so_oe_out  <= 1'b0;
            sio_oe_out <= 1'b0;
        end else begin
            tx_req_out <= 1'b0;
            if (!cs_act || (state_q != sfcd_pkg::SFCD_DOUT &&
                            state_q != sfcd_pkg::SFCD_HDR)) begin
                so_oe_out  <= 1'b0;
                sio_oe_out <= 1'b0;
                so_out     <= 1'b0;
                sio_out    <= 1'b0;
            end else if (state_q == sfcd_pkg::SFCD_HDR) begin
                if (info_q.dir == sfcd_pkg::SFCD_OUT) begin
                    txsh_q     <= tx_data_in;
                    tx_req_out <= 1'b1;
                    tbit_q     <= 3'h0;
                    tbyte_q    <= 3'h1;
                end
            end else begin
                so_oe_out  <= 1'b1;
                sio_oe_out <= info_q.dual;
                if (sck_fall) begin
                    so_out  <= txsh_q[7];
                    sio_out <= txsh_q[6];
                    if (tx_last) begin
                        tbit_q <= 3'h0;
                        // id read pads with zero past its last byte
                        if (info_q.maxb != 3'h0 &&
                            tbyte_q == info_q.maxb) begin
                            txsh_q <= 8'h00;
                        end else begin
                            txsh_q     <= tx_data_in;
                            tx_req_out <= 1'b1;
                            tbyte_q    <= tbyte_q + 3'h1;
                        end
                    end else begin
                        tbit_q <= tbit_q + 3'h1;
                        txsh_q <= info_q.dual ? {txsh_q[5:0], 2'b00}
                                              : {txsh_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    sfcd_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (mclk_in),
        .rst_in       (sys_rst_in),
        .in_valid_in  (push_q),
        .in_ready_out (fifo_ready),
        .in_data_in   (push_data_q),
        .out_valid_out(wr_valid_out),
        .out_ready_in (wr_ready_in),
        .out_data_out (wr_data_out)
    );
endmodule

// [rtl/sfcd_cfg.svh]
// constants of the serial flash command decoder
`ifndef SFCD_CFG_SVH
`define SFCD_CFG_SVH
`define SFCD_OP_RD_HS    8'h1B
`define SFCD_OP_RD_FAST  8'h0B
`define SFCD_OP_RD_LF    8'h03
`define SFCD_OP_RD_DUAL  8'h3B
`define SFCD_OP_ER_4K    8'h20
`define SFCD_OP_ER_32K   8'h52
`define SFCD_OP_ER_64K   8'hD8
`define SFCD_OP_ER_CHIPA 8'h60
`define SFCD_OP_ER_CHIPB 8'hC7
`define SFCD_OP_PROG     8'h02
`define SFCD_OP_PROG_DI  8'hA2
`define SFCD_OP_SUSPEND  8'hB0
`define SFCD_OP_RESUME   8'hD0
`define SFCD_OP_WR_EN    8'h06
`define SFCD_OP_WR_DIS   8'h04
`define SFCD_OP_PROT     8'h36
`define SFCD_OP_UNPROT   8'h39
`define SFCD_OP_RD_PROT  8'h3C
`define SFCD_OP_LOCK     8'h33
`define SFCD_OP_FREEZE   8'h34
`define SFCD_OP_RD_LOCK  8'h35
`define SFCD_OP_OTP_PROG 8'h9B
`define SFCD_OP_OTP_RD   8'h77
`define SFCD_OP_RD_STAT  8'h05
`define SFCD_OP_WR_STAT1 8'h01
`define SFCD_OP_WR_STAT2 8'h31
`define SFCD_OP_RESET    8'hF0
`define SFCD_OP_RD_ID    8'h9F
`define SFCD_OP_PD_ENTER 8'hB9
`define SFCD_OP_PD_EXIT  8'hAB
`define SFCD_ADDR_BYTES  2'h3
`define SFCD_ID_MAX      3'h4
`define SFCD_FIFO_DEPTH  16
`endif

// [rtl/sfcd_pkg.sv]
// types of the serial flash command decoder
package sfcd_pkg;
    typedef enum logic [2:0] {
        SFCD_IDLE  = 3'b000,
        SFCD_OPC   = 3'b001,
        SFCD_ADDR  = 3'b010,
        SFCD_DUMMY = 3'b011,
        SFCD_HDR   = 3'b100,
        SFCD_DIN   = 3'b101,
        SFCD_DOUT  = 3'b110,
        SFCD_IGN   = 3'b111
    } sfcd_state_e;

    typedef enum logic [1:0] {
        SFCD_NONE = 2'b00,
        SFCD_IN   = 2'b01,
        SFCD_OUT  = 2'b10
    } sfcd_dir_e;

    typedef struct packed {
        logic      valid;
        logic [1:0] naddr;
        logic [1:0] ndummy;
        sfcd_dir_e dir;
        logic      dual;
        logic [2:0] maxb;  // 0: unlimited
    } sfcd_info_s;
endpackage

// [sim/sfcd_host_model.sv]
// spi host model driving the decoder's link pins
`timescale 1ns/100ps
module sfcd_host_model (
    input  wire logic mclk_in,  // bench clock
    output logic      cs_n_out, // chip select, low
    output logic      sck_out,  // serial clock, still outside frames
    output logic      si_out,   // data towards the device
    input  wire logic so_in,    // data from the device
    input  wire logic sio_in    // second line in dual read
);
    logic [7:0] rx_q[$];

    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b0;
        si_out   = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // half period of 10 mclk gives the 160 ns link clock
    task automatic frame(input logic [7:0] tx[$], input int nrd,
                         input bit mode3, input bit dual);
        logic [7:0] b;
        int         nb;
        rx_q.delete();
        @(posedge mclk_in);
        sck_out  <= mode3;
        cs_n_out <= 1'b0;
        gap(10);
        for (int i = 0; i < tx.size() + nrd; i++) begin
            nb = (i >= tx.size() && dual) ? 4 : 8;
            for (int k = 0; k < nb; k++) begin
                sck_out <= 1'b0;
                // released line toggles so a stale bit never passes
                si_out  <= (i < tx.size()) ? tx[i][7-k] : ~si_out;
                gap(10);
                sck_out <= 1'b1;
                b = dual ? {b[5:0], so_in, sio_in} : {b[6:0], so_in};
                gap(10);
            end
            if (i >= tx.size())
                rx_q.push_back(b);
        end
        sck_out  <= mode3;
        cs_n_out <= 1'b1;
        gap(30);
    endtask
endmodule

// [sim/sfcd_decoder_chk.sv]
// assertions on the decoder's pins
`timescale 1ns/100ps
module sfcd_decoder_chk (
    input wire logic       mclk_in,       // clock
    input wire logic       sys_rst_in,    // reset
    input wire logic       cs_n_in,       // select pin
    input wire logic       sck_in,        // link clock pin
    input wire logic       so_out,        // read data
    input wire logic       so_oe_out,     // read data enable
    input wire logic       sio_oe_out,    // dual line enable
    input wire logic       cmd_start_out, // header pulse
    input wire logic       cmd_end_out,   // close pulse
    input wire logic       overrun_out,   // fifo overrun
    input wire logic       wr_valid_out,  // fifo not empty
    input wire logic       wr_ready_in,   // fifo drain
    input wire logic [7:0] wr_data_out    // fifo head
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    chk_release_quiet: assert property (
        cs_n_in [*7] |-> !so_oe_out && !sio_oe_out)
        else $error("output driven with select high");
    chk_idle_low: assert property (!so_oe_out |-> !so_out)
        else $error("read line not low while idle");
    chk_start_framed: assert property (
        cmd_start_out |-> !$past(cs_n_in, 3))
        else $error("header pulse outside a frame");
    chk_start_once: assert property (
        cmd_start_out |=> !cmd_start_out [*8])
        else $error("header pulse repeated");
    chk_end_after: assert property (
        cmd_end_out |-> cs_n_in && $past(cs_n_in))
        else $error("close pulse while selected");
    chk_end_once: assert property (
        cmd_end_out |=> !cmd_end_out [*8])
        else $error("close pulse repeated");
    chk_dual_pair: assert property (sio_oe_out |-> so_oe_out)
        else $error("second line driven alone");
    chk_shift_fall: assert property (
        so_oe_out && $past(so_oe_out) && $changed(so_out)
        |-> !sck_in && $past(sck_in, 6))
        else $error("read bit changed off a falling edge");
    chk_oe_start: assert property (
        $rose(so_oe_out) |-> $past(cmd_start_out))
        else $error("read drive without header");
    chk_overrun_full: assert property (overrun_out |-> wr_valid_out)
        else $error("overrun with empty fifo");
    chk_wr_hold: assert property (
        wr_valid_out && !wr_ready_in
        |=> wr_valid_out && $stable(wr_data_out))
        else $error("fifo head lost while stalled");
endmodule

bind sfcd_decoder sfcd_decoder_chk sfcd_decoder_chk_i (
    .mclk_in, .sys_rst_in, .cs_n_in, .sck_in, .so_out, .so_oe_out,
    .sio_oe_out, .cmd_start_out, .cmd_end_out, .overrun_out,
    .wr_valid_out, .wr_ready_in, .wr_data_out);

// [sim/tb_top.sv]
// self-checking bench for the serial flash command decoder
`timescale 1ns/100ps
`include "sfcd_cfg.svh"
module tb_top;
    logic        mclk, rst, cs_n, sck, si_h, si_w, so_w, tgl, stall;
    logic        so_o, so_oe, sio_o, sio_oe, c_start, c_end, ovr;
    logic        tx_req, wr_valid, wr_ready;
    logic [7:0]  c_op, tx_data, wr_data;
    logic [22:0] c_addr;
    logic [31:0] seed, last_c;
    logic [7:0]  seen_w[$], ew[$], sent[$];
    logic [7:0]  ops[30] = '{8'h1B, 8'h0B, 8'h03, 8'h3B, 8'h20, 8'h52,
        8'hD8, 8'h60, 8'hC7, 8'h02, 8'hA2, 8'hB0, 8'hD0, 8'h06, 8'h04,
        8'h36, 8'h39, 8'h3C, 8'h33, 8'h34, 8'h35, 8'h9B, 8'h77, 8'h05,
        8'h01, 8'h31, 8'hF0, 8'h9F, 8'hB9, 8'hAB};
    int          errors, n_checks, n_start, n_end, n_ovr;

    // dual read turns the host's data line round
    assign si_w = sio_oe ? sio_o : si_h;
    assign so_w = so_oe ? so_o : tgl;

    sfcd_decoder sfcd_decoder_i (.mclk_in(mclk), .sys_rst_in(rst),
        .cs_n_in(cs_n), .sck_in(sck), .si_in(si_w), .so_out(so_o),
        .so_oe_out(so_oe), .sio_out(sio_o), .sio_oe_out(sio_oe),
        .cmd_start_out(c_start), .cmd_opcode_out(c_op),
        .cmd_addr_out(c_addr), .cmd_end_out(c_end), .overrun_out(ovr),
        .tx_data_in(tx_data), .tx_req_out(tx_req),
        .wr_valid_out(wr_valid), .wr_ready_in(wr_ready),
        .wr_data_out(wr_data));

    sfcd_host_model sfcd_host_model_i (.mclk_in(mclk), .cs_n_out(cs_n),
        .sck_out(sck), .si_out(si_h), .so_in(so_w), .sio_in(si_w));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // naddr*100 + ndummy*10 + kind; kind 1 one byte in, 2 many, 3 out
    function automatic int info(input logic [7:0] op);
        case (op)
            8'h1B, 8'h77: return 323;
            8'h0B, 8'h3B: return 313;
            8'h03, 8'h3C, 8'h35: return 303;
            8'h20, 8'h52, 8'hD8, 8'h36, 8'h39: return 300;
            8'h60, 8'hC7, 8'hB0, 8'hD0: return 0;
            8'h06, 8'h04, 8'hB9, 8'hAB: return 0;
            8'h02, 8'hA2, 8'h9B: return 302;
            8'h33, 8'h34: return 301;
            8'h01, 8'h31, 8'hF0: return 1;
            8'h05, 8'h9F: return 3;
            default: return -1;
        endcase
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge mclk) begin
        tgl <= ~tgl;
        seed <= lfsr(seed);
        wr_ready <= stall ? 1'b0 : seed[9];
        if (c_start === 1'b1) begin
            n_start++;
            last_c <= {c_op, 1'b0, c_addr};
        end
        if (c_end === 1'b1)
            n_end++;
        if (ovr === 1'b1)
            n_ovr++;
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            seen_w.push_back(wr_data);
        if (tx_req === 1'b1) begin
            sent.push_back(tx_data);
            tx_data <= seed[7:0];
        end
    end

    task automatic run(input logic [7:0] op, input int nd, input bit m3,
                       input bit cut);
        logic [7:0]  tx[$];
        logic [31:0] r;
        int          f;
        int          k;
        f = info(op);
        r = seed;
        tx = {op};
        ew.delete();
        sent.delete();
        seen_w.delete();
        n_start = 0;
        n_end = 0;
        n_ovr = 0;
        if (f >= 100)
            tx = {tx, r[23:16], r[15:8], r[7:0]};
        repeat (f / 10 % 10) tx.push_back(8'h5A);
        for (int i = 0; i < nd && f % 10 != 3; i++) begin
            r = lfsr(r);
            tx.push_back(r[7:0]);
            if ((f % 10 == 2 && !(stall && i >= `SFCD_FIFO_DEPTH)) ||
                (f % 10 == 1 && i == 0))
                ew.push_back(r[7:0]);
        end
        if (cut) begin
            // header never completes, so no data reaches the fifo
            tx = tx[0:2];
            ew.delete();
        end
        sfcd_host_model_i.frame(tx, (f % 10 == 3) ? nd : 0, m3,
                                op == 8'h3B);
        chk(n_ovr, stall);
        stall = 1'b0;
        for (k = 0; k < 400 && wr_valid !== 1'b0; k++)
            @(posedge mclk);
        if (k == 400) begin
            errors++;
            summarize();
        end
        chk(n_start, f >= 0 && !cut);
        chk(n_end, f >= 0 && !cut);
        if (!cut && f >= 100)
            chk(last_c, {op, 1'b0, tx[1][6:0], tx[2], tx[3]});
        else if (f >= 0 && !cut)
            chk(last_c[31:24], op);
        chk(seen_w.size(), ew.size());
        foreach (ew[i])
            chk(seen_w[i], ew[i]);
        foreach (sfcd_host_model_i.rx_q[i])
            chk(sfcd_host_model_i.rx_q[i], sent[i]);
    endtask

    initial begin
        rst = 1'b1;
        stall = 1'b0;
        tgl = 1'b0;
        seed = 32'h4e68;
        tx_data = 8'h00;
        wr_ready = 1'b0;
        last_c = 32'h0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        foreach (ops[i])
            run(ops[i], 2, i[0], 1'b0);
        run(8'hFF, 4, 1'b0, 1'b0);
        run(8'h9F, 4, 1'b1, 1'b0);
        run(8'h02, 2, 1'b0, 1'b1);
        // stalled consumer fills the fifo and forces an overrun
        stall = 1'b1;
        run(8'hA2, 18, 1'b1, 1'b0);
        run(8'h03, 3, 1'b0, 1'b0);
        summarize();
    end
endmodule
